// [src/apm_pkg.sv]
package apm_pkg;
   // Mode decoded from the straps
   typedef enum logic [2:0] {
      APM_TERMINAL = 3'b001,
      APM_LINE_S   = 3'b010,
      APM_LINE_T   = 3'b100
   } apm_mode_t;

   // Register word offsets (byte address bits 5:2)
   localparam logic [3:0] REG_CTRL      = 4'h0;
   localparam logic [3:0] REG_TX_COUNT  = 4'h1;
   localparam logic [3:0] REG_RX_BLOCK  = 4'h2;
   localparam logic [3:0] REG_GPIO_DIR  = 4'h3;
   localparam logic [3:0] REG_GPIO_OUT  = 4'h4;
   localparam logic [3:0] REG_GPIO_IN   = 4'h5;
   localparam logic [3:0] REG_STATUS    = 4'h6;
   localparam logic [3:0] REG_IRQ_STAT  = 4'h7;
   localparam logic [3:0] REG_IRQ_EN    = 4'h8;
   localparam logic [3:0] REG_IRQ_CLR   = 4'h9;
   localparam logic [3:0] REG_PCM_TX    = 4'hA;
   localparam logic [3:0] REG_PCM_RX    = 4'hB;

   // Control fields
   localparam int CTRL_INT_SEL = 0;   // Pin 2 carries active-high interrupt
   localparam int CTRL_BITCLK  = 1;   // Pin 3 carries bit clock, else frame sync
   localparam int CTRL_RX_REQ  = 2;   // Receive FIFO wants emptying

   localparam int          TX_BLOCK      = 64;
   localparam int          FRAME_DIV     = 192;
   localparam int          PCM_BITS      = 8;
   localparam logic [15:0] TX_COUNT_RST  = 16'h0000;
   localparam logic [2:0]  RX_BLOCK_RST  = 3'h0;
   localparam logic [3:0]  GPIO_DIR_RST  = 4'h0;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

   // Interrupt status bits
   localparam int IRQ_TX_DONE  = 0;
   localparam int IRQ_RX_BLOCK = 1;
   localparam int IRQ_PCM_RX   = 2;
   localparam int IRQ_W        = 3;

   typedef struct packed {
      logic       rd;
      logic       wr_n;
      logic       dack_n;
   } apm_dma_strb_t;

   typedef struct packed {
      logic [5:0] o;
      logic [5:0] oe_n;
   } apm_pins_t;
endpackage : apm_pkg

// [src/apm_aux_mux.sv]
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Function
// RQ1: Straps pick terminal, line S, line T
// RQ2: Pin 0 is transmit request in terminal
// RQ3: Host loads transmit byte count first
// RQ4: Transmit in 64-byte blocks plus remainder
// RQ5: Drop transmit request after last write
// RQ6: Pin 1 is receive request in terminal
// RQ7: Receive blocks of 64,32,16,8,4 bytes
// RQ8: Drop receive request after last read
// RQ9: Acknowledge with strobe selects FIFO top
// RQ10: Line modes: pins 0-2 select channel
// RQ11: Pin 2 optional active-high interrupt
// RQ12: Pins 2-5 general purpose in terminal
// RQ13: Pin 3 frame sync, clock over 192
// RQ14: Pin 3 alternatively single bit clock
// RQ15: Pin 4 PCM input into timeslot
// RQ16: Pin 5 PCM output from timeslot
// RQ17: GPIO pins reset as inputs
// RQ18: PCM shifts aligned to highway frame
module apm_aux_mux #(
   parameter int FRAME_DIV = apm_pkg::FRAME_DIV
) (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   // Avalon-MM slave
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Straps and highway
   input  wire logic        mode_strap_0,
   input  wire logic        mode_strap_1,
   input  wire logic        highway_data_clock,
   input  wire logic        highway_frame_sync,
   // DMA strobes, active low
   input  wire logic        dma_ack_chan_a_n,
   input  wire logic        rd_n,
   input  wire logic        wr_n,
   // Device interrupt (active low source)
   input  wire logic        int_line_n,
   // Auxiliary pins
   input  wire logic [5:0]  aux_pin_in,
   output logic      [5:0]  aux_pin_out,
   output logic      [5:0]  aux_pin_oe_n,
   // Interrupt
   output logic             irq
);
   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   localparam int NS = 12;
   logic [NS-1:0] sync1;
   logic [NS-1:0] sync2;
   logic [NS-1:0] raw;
   assign raw = {aux_pin_in, mode_strap_0, mode_strap_1, highway_data_clock,
                 highway_frame_sync, dma_ack_chan_a_n, rd_n};
   logic wr_s1;
   logic wr_s2;
   logic int_s1;
   logic int_s2;
   // Not reset: the straps must have settled by the time the mode is caught
   always_ff @(posedge ref_clk)
      if (clk_en)
      begin
         sync1 <= raw;
         sync2 <= sync1;
         wr_s1 <= wr_n;
         wr_s2 <= wr_s1;
         int_s1 <= int_line_n;
         int_s2 <= int_s1;
      end

   logic [5:0] pin_s;
   logic       strap0;
   logic       strap1;
   logic       dcl_s;
   logic       fsc_s;
   logic       dack_n_s;
   logic       rd_n_s;
   assign {pin_s, strap0, strap1, dcl_s, fsc_s, dack_n_s, rd_n_s} = sync2;

   // ------------------------------------------------------------
   // Mode, caught after reset release
   // ------------------------------------------------------------
   apm_pkg::apm_mode_t mode;
   logic               mode_valid;
   always_ff @(posedge ref_clk)
      if (rst)
      begin
         mode       <= apm_pkg::APM_TERMINAL;
         mode_valid <= 1'b0;
      end
      else if (clk_en)
      begin
         mode_valid <= 1'b1;
         if (!mode_valid) // RQ1
            mode <= !strap0 ? apm_pkg::APM_TERMINAL :
                    (strap1 ? apm_pkg::APM_LINE_T : apm_pkg::APM_LINE_S);
      end
   logic term;
   assign term = mode_valid && (mode == apm_pkg::APM_TERMINAL);

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [2:0]  ctrl;
   logic [15:0] tx_count;
   logic [2:0]  rx_block;
   logic [3:0]  gpio_dir;
   logic [3:0]  gpio_out;
   localparam int IRQ_W_L = apm_pkg::IRQ_W;
   logic [IRQ_W_L-1:0] irq_stat;
   logic [IRQ_W_L-1:0] irq_en;
   logic [7:0]  pcm_tx;
   logic [7:0]  pcm_rx;
   logic [IRQ_W_L-1:0] irq_set;
   logic        tx_load;
   logic        bus_ack;
   logic [3:0]  widx;
   assign widx    = avs_address[5:2];
   assign tx_load = avs_write && avs_waitrequest && (widx == apm_pkg::REG_TX_COUNT);

   // One wait state per access; answer at second edge
   always_ff @(posedge ref_clk)
      if (rst)
         bus_ack <= 1'b0;
      else if (clk_en)
         bus_ack <= (avs_read || avs_write) && !bus_ack;
   always_ff @(posedge ref_clk)
      if (rst)
         avs_waitrequest <= 1'b1;
      else if (clk_en)
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest && !bus_ack);

   always_ff @(posedge ref_clk)
      if (rst)
      begin
         ctrl     <= 3'h0;
         tx_count <= apm_pkg::TX_COUNT_RST;
         rx_block <= apm_pkg::RX_BLOCK_RST;
         gpio_dir <= apm_pkg::GPIO_DIR_RST; // RQ17
         gpio_out <= 4'h0;
         irq_en   <= '0;
         pcm_tx   <= 8'h00;
      end
      else if (clk_en && avs_write && !avs_waitrequest)
         unique case (widx)
            apm_pkg::REG_CTRL:     ctrl     <= avs_writedata[2:0];
            apm_pkg::REG_TX_COUNT: tx_count <= avs_writedata[15:0]; // RQ3
            apm_pkg::REG_RX_BLOCK: rx_block <= avs_writedata[2:0];
            apm_pkg::REG_GPIO_DIR: gpio_dir <= avs_writedata[3:0]; // RQ12
            apm_pkg::REG_GPIO_OUT: gpio_out <= avs_writedata[3:0]; // RQ12
            apm_pkg::REG_IRQ_EN:   irq_en   <= avs_writedata[IRQ_W_L-1:0];
            apm_pkg::REG_PCM_TX:   pcm_tx   <= avs_writedata[7:0];
            default: ;
         endcase

   // Set wins over clear
   always_ff @(posedge ref_clk)
      if (rst)
         irq_stat <= '0;
      else if (clk_en)
         irq_stat <= (irq_stat & ~((avs_write && !avs_waitrequest &&
                      widx == apm_pkg::REG_IRQ_CLR) ? avs_writedata[IRQ_W_L-1:0] : '0))
                     | irq_set;

   // ------------------------------------------------------------
   // Transmit DMA
   // ------------------------------------------------------------
   logic [15:0] tx_left;
   logic [6:0]  tx_in_blk;
   logic        tx_req;
   logic        wr_fall;
   logic        wr_prev;
   logic        dma_wr;
   logic        rd_prev;
   logic        dma_rd;
   assign dma_wr  = !dack_n_s && !wr_s2; // RQ9
   assign dma_rd  = !dack_n_s && !rd_n_s; // RQ9
   always_ff @(posedge ref_clk)
      if (rst)
      begin
         wr_prev <= 1'b0;
         rd_prev <= 1'b0;
      end
      else if (clk_en)
      begin
         wr_prev <= dma_wr;
         rd_prev <= dma_rd;
      end
   assign wr_fall = dma_wr && !wr_prev;

   function automatic logic [6:0] blk_len(input logic [15:0] left);
      blk_len = (left >= 16'(apm_pkg::TX_BLOCK)) ? 7'(apm_pkg::TX_BLOCK) : left[6:0];
   endfunction : blk_len

   always_ff @(posedge ref_clk)
      if (rst)
      begin
         tx_left   <= 16'h0000;
         tx_in_blk <= 7'h00;
         tx_req    <= 1'b0;
      end
      else if (clk_en)
      begin
         if (tx_load)
         begin
            tx_left   <= avs_writedata[15:0];
            tx_in_blk <= blk_len(avs_writedata[15:0]);
            tx_req    <= term && (avs_writedata[15:0] != 16'h0000); // RQ2
         end
         else if (tx_req && wr_fall)
         begin
            tx_left <= tx_left - 16'h0001;
            if (tx_in_blk == 7'h01)
            begin
               tx_req    <= 1'b0; // RQ5
               tx_in_blk <= blk_len(tx_left - 16'h0001);
            end
            else
               tx_in_blk <= tx_in_blk - 7'h01;
         end
         else if (!tx_req && !dma_wr && tx_left != 16'h0000 && term)
            tx_req <= 1'b1; // RQ4
      end

   // ------------------------------------------------------------
   // Receive DMA
   // ------------------------------------------------------------
   logic [6:0] rx_cnt;
   logic       rx_req;
   logic       rd_fall;
   assign rd_fall = dma_rd && !rd_prev;
   // Codes above 4 all give the smallest block
   function automatic logic [6:0] rx_size(input logic [2:0] sel);
      rx_size = 7'(apm_pkg::TX_BLOCK) >> ((sel > 3'h4) ? 3'h4 : sel);
   endfunction : rx_size

   always_ff @(posedge ref_clk)
      if (rst)
      begin
         rx_req <= 1'b0;
         rx_cnt <= 7'h00;
      end
      else if (clk_en)
      begin
         if (!rx_req && term && ctrl[apm_pkg::CTRL_RX_REQ] && !dma_rd)
         begin
            rx_req <= 1'b1; // RQ6
            rx_cnt <= rx_size(rx_block); // RQ7
         end
         else if (rx_req && rd_fall)
         begin
            rx_cnt <= rx_cnt - 7'h01;
            if (rx_cnt == 7'h01)
               rx_req <= 1'b0; // RQ8
         end
      end

   // ------------------------------------------------------------
   // Highway frame, bit clock and PCM
   // ------------------------------------------------------------
   logic       dcl_prev;
   logic       fsc_prev;
   logic [7:0] div_cnt;
   logic       frame_out;
   logic [8:0] bit_cnt;
   logic [7:0] pcm_sh_in;
   logic [7:0] pcm_sh_out;
   logic       dcl_rise;
   logic       dcl_fall;
   logic       fsc_rise;
   logic [2:0] chan;
   logic       in_slot;
   logic       bitclk;
   assign dcl_rise = dcl_s && !dcl_prev;
   assign dcl_fall = !dcl_s && dcl_prev;
   assign fsc_rise = fsc_s && !fsc_prev;
   assign chan     = pin_s[2:0]; // RQ10
   // Two clocks per bit; 4 slots of 8 bits per channel, slot 0 of chan used
   assign in_slot  = (bit_cnt[8:6] == chan) && (bit_cnt[5:4] == 2'b00);

   always_ff @(posedge ref_clk)
      if (rst)
      begin
         dcl_prev  <= 1'b0;
         fsc_prev  <= 1'b0;
         div_cnt   <= 8'h00;
         frame_out <= 1'b0;
         bit_cnt   <= 9'h000;
         bitclk    <= 1'b0;
      end
      else if (clk_en)
      begin
         dcl_prev <= dcl_s;
         fsc_prev <= fsc_s;
         if (dcl_rise)
         begin
            bitclk <= !bitclk; // RQ14
            // Free-running: the highway frame need not be a multiple of the divider
            if (div_cnt == 8'(FRAME_DIV - 1))
               div_cnt <= 8'h00;
            else
               div_cnt <= div_cnt + 8'h01;
            frame_out <= (div_cnt < 8'(FRAME_DIV / 2)); // RQ13
            bit_cnt <= fsc_rise ? 9'h000 : bit_cnt + 9'h001; // RQ18
         end
      end

   always_ff @(posedge ref_clk)
      if (rst)
      begin
         pcm_sh_in  <= 8'h00;
         pcm_sh_out <= 8'h00;
         pcm_rx     <= 8'h00;
         irq_set    <= '0;
      end
      else if (clk_en)
      begin
         irq_set <= '0;
         if (tx_req && wr_fall && tx_in_blk == 7'h01 && tx_left == 16'h0001)
            irq_set[apm_pkg::IRQ_TX_DONE] <= 1'b1;
         if (rx_req && rd_fall && rx_cnt == 7'h01)
            irq_set[apm_pkg::IRQ_RX_BLOCK] <= 1'b1;
         if (!term && in_slot && bit_cnt[0])
         begin
            if (dcl_fall)
            begin
               pcm_sh_in <= {pcm_sh_in[6:0], pin_s[4]}; // RQ15
               if (bit_cnt[3:1] == 3'h7)
               begin
                  pcm_rx <= {pcm_sh_in[6:0], pin_s[4]};
                  irq_set[apm_pkg::IRQ_PCM_RX] <= 1'b1;
               end
            end
         end
         if (!term && dcl_rise)
         begin
            if (bit_cnt[8:0] == {chan, 6'h00} - 9'h001 || (fsc_rise && chan == 3'h0))
               pcm_sh_out <= pcm_tx; // RQ16
            else if (in_slot && bit_cnt[0])
               pcm_sh_out <= {pcm_sh_out[6:0], 1'b0}; // RQ18
         end
      end

   // ------------------------------------------------------------
   // Pin multiplexing and outputs
   // ------------------------------------------------------------
   apm_pkg::apm_pins_t next_pins;
   always_comb
   begin
      next_pins.o    = 6'h00;
      next_pins.oe_n = 6'h3F;
      if (term)
      begin
         next_pins.o[0]    = tx_req; // RQ2
         next_pins.oe_n[0] = 1'b0;
         next_pins.o[1]    = rx_req; // RQ6
         next_pins.oe_n[1] = 1'b0;
         next_pins.o[5:2]    = gpio_out; // RQ12
         next_pins.oe_n[5:2] = ~gpio_dir;
         if (ctrl[apm_pkg::CTRL_INT_SEL])
         begin
            next_pins.o[2]    = !int_s2; // RQ11
            next_pins.oe_n[2] = 1'b0;
         end
      end
      else if (mode_valid)
      begin
         // Pins stay released until the mode is known, so no select pin is driven
         next_pins.o[3]    = ctrl[apm_pkg::CTRL_BITCLK] ? bitclk : frame_out; // RQ13 RQ14
         next_pins.oe_n[3] = 1'b0;
         next_pins.o[5]    = pcm_sh_out[7]; // RQ16
         next_pins.oe_n[5] = 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
      if (rst)
      begin
         aux_pin_out  <= 6'h00;
         aux_pin_oe_n <= 6'h3F; // RQ17
         irq          <= 1'b0;
      end
      else if (clk_en)
      begin
         aux_pin_out  <= next_pins.o;
         aux_pin_oe_n <= next_pins.oe_n;
         irq          <= |(irq_stat & irq_en);
      end

   always_ff @(posedge ref_clk)
      if (rst)
         avs_readdata <= apm_pkg::UNMAPPED_DATA;
      else if (clk_en && avs_read && avs_waitrequest)
         unique case (widx)
            apm_pkg::REG_CTRL:     avs_readdata <= {29'h0, ctrl};
            apm_pkg::REG_TX_COUNT: avs_readdata <= {16'h0, tx_count};
            apm_pkg::REG_RX_BLOCK: avs_readdata <= {29'h0, rx_block};
            apm_pkg::REG_GPIO_DIR: avs_readdata <= {28'h0, gpio_dir};
            apm_pkg::REG_GPIO_OUT: avs_readdata <= {28'h0, gpio_out};
            apm_pkg::REG_GPIO_IN:  avs_readdata <= {28'h0, pin_s[5:2]};
            apm_pkg::REG_STATUS:   avs_readdata <= {22'h0, mode, rx_req, tx_req, tx_left[4:0]};
            apm_pkg::REG_IRQ_STAT: avs_readdata <= {29'h0, irq_stat};
            apm_pkg::REG_IRQ_EN:   avs_readdata <= {29'h0, irq_en};
            apm_pkg::REG_PCM_RX:   avs_readdata <= {24'h0, pcm_rx};
            default:               avs_readdata <= apm_pkg::UNMAPPED_DATA;
         endcase

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_tx_req_drop: assert property (@(posedge ref_clk) disable iff (rst) // RQ5
      clk_en && tx_req && wr_fall && tx_in_blk == 7'h01 |=> !tx_req)
      else $error("transmit request not dropped after last write");
   a_rx_req_drop: assert property (@(posedge ref_clk) disable iff (rst) // RQ8
      clk_en && rx_req && rd_fall && rx_cnt == 7'h01 |=> !rx_req)
      else $error("receive request not dropped after last read");
   a_pin0_txreq: assert property (@(posedge ref_clk) disable iff (rst) // RQ2
      clk_en && term |=> aux_pin_out[0] == $past(tx_req) && !aux_pin_oe_n[0])
      else $error("pin 0 does not follow transmit request");
   a_blk_bound: assert property (@(posedge ref_clk) disable iff (rst) // RQ4
      tx_in_blk <= 7'(apm_pkg::TX_BLOCK))
      else $error("transmit block exceeds 64");
   a_line_inputs: assert property (@(posedge ref_clk) disable iff (rst) // RQ10
      mode_valid && !term |-> ##1 aux_pin_oe_n[2:0] == 3'h7)
      else $error("channel select pins driven in line mode");
   a_int_invert: assert property (@(posedge ref_clk) disable iff (rst) // RQ11
      clk_en && term && ctrl[apm_pkg::CTRL_INT_SEL] |=> aux_pin_out[2] == !$past(int_s2))
      else $error("pin 2 interrupt not inverted");
   a_gpio_reset: assert property (@(posedge ref_clk) // RQ17
      $past(rst) |-> aux_pin_oe_n == 6'h3F)
      else $error("pins not released after reset");
   a_frame_wrap: assert property (@(posedge ref_clk) disable iff (rst) // RQ13
      div_cnt < 8'(FRAME_DIV))
      else $error("frame divider out of range");
endmodule : apm_aux_mux
`default_nettype wire

// [sim/apm_dma_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Channel A DMA controller: serves a request with strobes until it drops
module apm_dma_model (
   // Clock
   input  wire logic        ref_clk,
   // Requests from the block
   input  wire logic        tx_req,
   input  wire logic        rx_req,
   // Acknowledge and strobes, active low
   output logic             dma_ack_chan_a_n,
   output logic             wr_n,
   output logic             rd_n,
   // Log of finished bursts
   output logic [15:0]      burst_cnt,
   output logic [7:0]       burst_len
);
   logic is_tx;
   logic ended;
   int   n;

   initial
   begin
      dma_ack_chan_a_n = 1'b1;
      wr_n = 1'b1;
      rd_n = 1'b1;
      burst_cnt = 16'h0000;
      burst_len = 8'h00;
      forever
      begin
         @(posedge ref_clk);
         if (tx_req || rx_req)
         begin
            is_tx = tx_req;
            ended = 1'b0;
            n = 0;
            dma_ack_chan_a_n <= 1'b0;
            while (!ended)
            begin
               @(posedge ref_clk);
               if (is_tx)
                  wr_n <= 1'b0;
               else
                  rd_n <= 1'b0;
               // Request must be gone well before the strobe ends
               repeat (6) @(posedge ref_clk);
               ended = is_tx ? !tx_req : !rx_req;
               n = n + 1;
               wr_n <= 1'b1;
               rd_n <= 1'b1;
               repeat (4) @(posedge ref_clk);
            end
            dma_ack_chan_a_n <= 1'b1;
            burst_len <= n[7:0];
            burst_cnt <= burst_cnt + 16'h0001;
            // Pause lets the host retire a request before the next burst
            repeat (30) @(posedge ref_clk);
         end
      end
   end
endmodule : apm_dma_model
`default_nettype wire

// [sim/apm_aux_mux_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module apm_aux_mux_tb_top;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic        ref_clk;
   logic        rst;
   logic        clk_en;
   logic [5:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        mode_strap_0;
   logic        mode_strap_1;
   logic        highway_data_clock;
   logic        highway_frame_sync;
   logic        dma_ack_chan_a_n;
   logic        rd_n;
   logic        wr_n;
   logic        int_line_n;
   logic [5:0]  aux_pin_in;
   logic [5:0]  aux_pin_out;
   logic [5:0]  aux_pin_oe_n;
   logic        irq;
   logic [5:0]  pin_drv;
   logic        loop_en;
   logic [5:0]  pin_ext;
   logic [15:0] burst_cnt;
   logic [7:0]  burst_len;
   logic [11:0] hw_cnt;
   logic [31:0] rd_data;
   logic [31:0] n;
   int          left;
   int          fails;
   int          checked;
   int          cycles;

   // Wire level: driver is the block when enabled, else the bench
   assign pin_ext = {pin_drv[5], loop_en ? aux_pin_out[5] : pin_drv[4], pin_drv[3:0]};
   assign aux_pin_in = (aux_pin_oe_n & pin_ext) | (~aux_pin_oe_n & aux_pin_out);

   apm_aux_mux #(.FRAME_DIV(apm_pkg::FRAME_DIV)) dut (
      .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .mode_strap_0(mode_strap_0),
      .mode_strap_1(mode_strap_1), .highway_data_clock(highway_data_clock),
      .highway_frame_sync(highway_frame_sync), .dma_ack_chan_a_n(dma_ack_chan_a_n),
      .rd_n(rd_n), .wr_n(wr_n), .int_line_n(int_line_n), .aux_pin_in(aux_pin_in),
      .aux_pin_out(aux_pin_out), .aux_pin_oe_n(aux_pin_oe_n), .irq(irq));

   apm_dma_model partner (
      .ref_clk(ref_clk), .tx_req(aux_pin_out[0] & ~aux_pin_oe_n[0]),
      .rx_req(aux_pin_out[1] & ~aux_pin_oe_n[1]), .dma_ack_chan_a_n(dma_ack_chan_a_n),
      .wr_n(wr_n), .rd_n(rd_n), .burst_cnt(burst_cnt), .burst_len(burst_len));

   initial
   begin
      ref_clk = 1'b0;
      forever
         #5 ref_clk = ~ref_clk;
   end

   // Highway: 6 cycles per data clock, frame of 512 data clocks
   always @(posedge ref_clk)
   begin
      hw_cnt <= (hw_cnt == 12'hBFF) ? 12'h000 : hw_cnt + 12'h001;
      highway_data_clock <= (hw_cnt % 12'h006) < 12'h003;
      highway_frame_sync <= hw_cnt < 12'h006;
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         fails = fails + 1;
         end_of_test();
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic end_of_test();
      if (fails == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked = checked + 1;
      if (got !== exp)
      begin
         fails = fails + 1;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] data);
      @(posedge ref_clk);
      avs_address <= {idx, 2'b00};
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= data;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge ref_clk);
      rd_data = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   task automatic do_reset(input logic s0, input logic s1);
      @(posedge ref_clk);
      mode_strap_0 <= s0;
      mode_strap_1 <= s1;
      rst <= 1'b1;
      repeat (8) @(posedge ref_clk);
      check({25'h0, irq, aux_pin_oe_n}, 32'h3F);
      rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask : do_reset

   task automatic wait_burst();
      logic [15:0] prev;
      prev = burst_cnt;
      @(posedge ref_clk);
      while (burst_cnt === prev)
         @(posedge ref_clk);
   endtask : wait_burst

   // Cycles between two rising edges of pin 3
   task automatic period(output logic [31:0] cnt);
      logic prev;
      int   k;
      cnt = 32'h0;
      prev = 1'b1;
      k = 0;
      while (k < 2)
      begin
         @(posedge ref_clk);
         if (aux_pin_out[3] === 1'b1 && !prev)
            k = k + 1;
         prev = aux_pin_out[3];
         if (k == 1)
            cnt = cnt + 32'h1;
      end
   endtask : period

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      rst = 1'b1;
      clk_en = 1'b1;
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      mode_strap_0 = 1'b0;
      mode_strap_1 = 1'b0;
      int_line_n = 1'b1;
      pin_drv = 6'h00;
      loop_en = 1'b0;
      hw_cnt = 12'h000;
      highway_data_clock = 1'b0;
      highway_frame_sync = 1'b0;
      fails = 0;
      checked = 0;
      cycles = 0;
      for (int m = 0; m < 3; m++)
      begin
         do_reset(m != 0, m == 2);
         bus(1'b0, apm_pkg::REG_STATUS, 32'h0);
         check({29'h0, rd_data[9:7]}, {29'h0, 3'h1 << m});
      end
      check({26'h0, aux_pin_oe_n}, 32'h17);
      period(n);
      check(n, 32'(6 * apm_pkg::FRAME_DIV));
      bus(1'b1, apm_pkg::REG_CTRL, 32'h2);
      repeat (30) @(posedge ref_clk);
      period(n);
      check(n, 32'h0000000C);
      pin_drv <= 6'h05;
      loop_en <= 1'b1;
      bus(1'b1, apm_pkg::REG_PCM_TX, 32'hA5);
      repeat (9216) @(posedge ref_clk);
      bus(1'b0, apm_pkg::REG_PCM_RX, 32'h0);
      check({24'h0, rd_data[7:0]}, 32'hA5);
      bus(1'b0, apm_pkg::REG_IRQ_STAT, 32'h0);
      check({31'h0, rd_data[apm_pkg::IRQ_PCM_RX]}, 32'h1);
      do_reset(1'b0, 1'b0);
      loop_en <= 1'b0;
      pin_drv <= 6'h04;
      check({30'h0, aux_pin_oe_n[1:0]}, 32'h0);
      bus(1'b1, apm_pkg::REG_GPIO_DIR, 32'hE);
      bus(1'b1, apm_pkg::REG_GPIO_OUT, 32'hA);
      repeat (6) @(posedge ref_clk);
      check({28'h0, aux_pin_oe_n[5:2]}, 32'h1);
      check({29'h0, aux_pin_out[5:3]}, 32'h5);
      bus(1'b0, apm_pkg::REG_GPIO_IN, 32'h0);
      check({31'h0, rd_data[0]}, 32'h1);
      bus(1'b0, apm_pkg::REG_GPIO_DIR, 32'h0);
      check(rd_data, 32'hE);
      bus(1'b1, apm_pkg::REG_CTRL, 32'h1);
      for (int v = 0; v < 2; v++)
      begin
         int_line_n <= v[0];
         repeat (6) @(posedge ref_clk);
         check({30'h0, aux_pin_oe_n[2], aux_pin_out[2]}, {31'h0, ~v[0]});
      end
      // Enable low: the pin must hold although its source moves
      clk_en <= 1'b0;
      int_line_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      check({31'h0, aux_pin_out[2]}, 32'h0);
      clk_en <= 1'b1;
      repeat (6) @(posedge ref_clk);
      check({31'h0, aux_pin_out[2]}, 32'h1);
      bus(1'b1, apm_pkg::REG_IRQ_EN, 32'h0);
      for (int i = 0; i < 2; i++)
      begin
         left = (i == 0) ? 70 : 64;
         bus(1'b1, apm_pkg::REG_TX_COUNT, left);
         while (left > 0)
         begin
            wait_burst();
            check({24'h0, burst_len}, (left > 64) ? 64 : left);
            left = left - ((left > 64) ? 64 : left);
         end
      end
      repeat (60) @(posedge ref_clk);
      check({16'h0, burst_cnt}, 32'h3);
      check({31'h0, irq}, 32'h0);
      bus(1'b1, apm_pkg::REG_IRQ_EN, 32'h1);
      bus(1'b0, apm_pkg::REG_IRQ_STAT, 32'h0);
      check({31'h0, rd_data[apm_pkg::IRQ_TX_DONE]}, 32'h1);
      check({31'h0, irq}, 32'h1);
      bus(1'b1, apm_pkg::REG_IRQ_CLR, 32'h1);
      bus(1'b0, apm_pkg::REG_IRQ_STAT, 32'h0);
      check({31'h0, rd_data[apm_pkg::IRQ_TX_DONE]}, 32'h0);
      check({31'h0, irq}, 32'h0);
      for (int c = 0; c < 5; c++)
      begin
         bus(1'b1, apm_pkg::REG_RX_BLOCK, c);
         // Need withdrawn once the request stands, so only one block is asked for
         bus(1'b1, apm_pkg::REG_CTRL, 32'h4);
         bus(1'b1, apm_pkg::REG_CTRL, 32'h0);
         wait_burst();
         check({24'h0, burst_len}, 32'h40 >> c);
         repeat (40) @(posedge ref_clk);
      end
      check({16'h0, burst_cnt}, 32'h8);
      bus(1'b0, apm_pkg::REG_IRQ_STAT, 32'h0);
      check({31'h0, rd_data[apm_pkg::IRQ_RX_BLOCK]}, 32'h1);
      bus(1'b1, 4'hC, 32'hFF);
      bus(1'b0, 4'hC, 32'h0);
      check(rd_data, apm_pkg::UNMAPPED_DATA);
      end_of_test();
   end
endmodule : apm_aux_mux_tb_top
`default_nettype wire
